// [verilog/itb_timer.sv]
// interval timer / clock time base with divided clock output
`timescale 1ns/1ns
`include "itb_regs.svh"
module itb_timer #(
  parameter int PSS_W = 13,
  parameter int PSW_W = 7
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_ce,
  input  wire logic                     i_subclock,
  input  wire logic                     i_port_mode_reg_one_out_en,
  input  wire logic [`ITB_ADDR_W-1:0]   i_addr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output itb_pkg::itb_byte_type         o_rdata,
  output logic                          o_overflow_request_flag,
  output logic                          o_divided_clock_out_pin,
  output logic                          o_divided_clock_out_pin_en
);

  // ****************************************
  // derived counts and parameter checks
  // ****************************************
  localparam longint SUB_CYC0 = longint'(`ITB_SUBCLK_HZ) * `ITB_PERIOD0_US
                                / `ITB_US_PER_S / `ITB_COUNT_STEPS;
  localparam longint SUB_CYC1 = longint'(`ITB_SUBCLK_HZ) * `ITB_PERIOD1_US
                                / `ITB_US_PER_S / `ITB_COUNT_STEPS;
  localparam longint SUB_CYC2 = longint'(`ITB_SUBCLK_HZ) * `ITB_PERIOD2_US
                                / `ITB_US_PER_S / `ITB_COUNT_STEPS;
  localparam longint SUB_CYC3 = longint'(`ITB_SUBCLK_HZ) * `ITB_PERIOD3_US
                                / `ITB_US_PER_S / `ITB_COUNT_STEPS;
  localparam int TB_W0 = $clog2(SUB_CYC0);
  localparam int TB_W1 = $clog2(SUB_CYC1);
  localparam int TB_W2 = $clog2(SUB_CYC2);
  localparam int TB_W3 = $clog2(SUB_CYC3);

  generate
    if (PSS_W < 13 || PSS_W > 16) begin : g_bad_pss
      $error("system prescaler width must be 13 to 16");
    end
    if (PSW_W < TB_W0 || PSW_W > 16) begin : g_bad_psw
      $error("subclock prescaler too narrow for the longest period");
    end
  endgenerate

  // ****************************************
  // functions
  // ****************************************
  // true when the low w bits of v are all ones, i.e. the next step carries past bit w-1
  function automatic logic low_ones(input logic [15:0] v, input logic [4:0] w);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i < int'(w) && !v[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction : low_ones

  function automatic logic [4:0] sys_tap_w(input logic [2:0] sel);
    case (sel)
      3'h0:    sys_tap_w = 5'h0D;
      3'h1:    sys_tap_w = 5'h0C;
      3'h2:    sys_tap_w = 5'h0B;
      3'h3:    sys_tap_w = 5'h09;
      3'h4:    sys_tap_w = 5'h08;
      3'h5:    sys_tap_w = 5'h07;
      3'h6:    sys_tap_w = 5'h05;
      default: sys_tap_w = 5'h03;
    endcase
  endfunction : sys_tap_w

  // ****************************************
  // reset release and subclock capture
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  logic sub_sync;
  logic sub_last;

  // without a running subclock sub_edge never fires and the time base stalls [R6]
  itb_sync u_sub_sync (
    .i_clk   (i_clk),
    .i_rst_b (rst_n),
    .i_ce    (i_ce),
    .i_async (i_subclock),
    .o_sync  (sub_sync)
  );

  // ****************************************
  // state
  // ****************************************
  itb_pkg::itb_byte_type  mode;
  itb_pkg::itb_byte_type  count;
  logic [PSS_W-1:0]       system_prescaler;
  logic [PSW_W-1:0]       subclock_prescaler;

  // ****************************************
  // decode and next values
  // ****************************************
  wire                    sub_edge   = sub_sync & ~sub_last;
  wire itb_pkg::itb_src_type src     = mode[`ITB_SRC_KIND_BIT] ? itb_pkg::ITB_SRC_SUB
                                                             : itb_pkg::ITB_SRC_SYSTEM;
  wire                    tb_clear   = (src == itb_pkg::ITB_SRC_SUB) & mode[`ITB_CLEAR_BIT];
  wire [2:0]              tap_sel    = mode[`ITB_SEL_MSB:`ITB_SEL_LSB];
  wire [1:0]              period_sel = mode[`ITB_PERIOD_MSB:`ITB_PERIOD_LSB];
  wire [4:0]              tb_w       = (period_sel == 2'h0) ? 5'(TB_W0) :
                                       (period_sel == 2'h1) ? 5'(TB_W1) :
                                       (period_sel == 2'h2) ? 5'(TB_W2) : 5'(TB_W3);
  wire                    sys_tick   = low_ones(16'(system_prescaler), sys_tap_w(tap_sel));
  wire                    tb_tick    = sub_edge & low_ones(16'(subclock_prescaler), tb_w);
  wire                    count_inc  = (src == itb_pkg::ITB_SRC_SUB) ? tb_tick : sys_tick;
  wire                    wraps      = count_inc & ~tb_clear & (count == `ITB_COUNT_MAX);
  wire                    sel_mode   = (i_addr == `ITB_MODE_OFFSET);
  wire                    sel_count  = (i_addr == `ITB_COUNT_OFFSET);
  wire [2:0]              out_bit    = 3'(`ITB_OUT_DIV32_BIT)
                                       - {1'b0, mode[`ITB_OUT_RATIO_MSB:`ITB_OUT_RATIO_LSB]};
  wire                    sel_clk    = mode[`ITB_OUT_SRC_BIT] ? subclock_prescaler[out_bit] : system_prescaler[out_bit];
  wire itb_pkg::itb_byte_type mode_view = mode | (8'h01 << `ITB_RSVD_BIT);

  wire itb_pkg::itb_byte_type next_count = tb_clear  ? `ITB_COUNT_RESET :
                                           count_inc ? count + 8'h01 : count;
  wire [PSW_W-1:0]        next_psw   = tb_clear ? '0 : sub_edge ? subclock_prescaler + 1'b1 : subclock_prescaler;
  wire itb_pkg::itb_byte_type next_rdata = !i_rd    ? `ITB_READ_NONE :
                                           sel_mode  ? mode_view :
                                           sel_count ? count : `ITB_READ_NONE;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= `ITB_MODE_RESET;
    end else if (i_ce && i_wr && sel_mode) begin
      mode <= i_wdata;                                            // [R7]
    end
  end

  // system prescaler runs free and the subclock one clears only on the clear bit, so a tap change takes effect at once, at the cost of a short first period
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_prescaler      <= '0;
      subclock_prescaler      <= '0;
      sub_last <= 1'b0;
    end else if (i_ce) begin
      system_prescaler      <= system_prescaler + 1'b1;                                     // [R2]
      subclock_prescaler      <= next_psw;                                       // [R3] [R10]
      sub_last <= sub_sync;
    end
  end

  // count register has no write path at all [R13]
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      count                   <= `ITB_COUNT_RESET;
      o_overflow_request_flag <= 1'b0;
    end else if (i_ce) begin
      count                   <= next_count;                      // [R1] [R9] [R10]
      o_overflow_request_flag <= wraps;                           // [R4] [R9]
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata                    <= `ITB_READ_NONE;
      o_divided_clock_out_pin    <= 1'b0;
      o_divided_clock_out_pin_en <= 1'b0;
    end else if (i_ce) begin
      o_rdata                    <= next_rdata;                   // [R7] [R8]
      o_divided_clock_out_pin    <= sel_clk & i_port_mode_reg_one_out_en; // [R5] [R11] [R12]
      o_divided_clock_out_pin_en <= i_port_mode_reg_one_out_en;   // [R12]
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_step;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && count_inc && !tb_clear && count != `ITB_COUNT_MAX)
      |=> (count == $past(count) + 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("count did not step by one"); // [R1]

  property p_hold;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && !count_inc && !tb_clear) |=> $stable(count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without a tap"); // [R2]

  property p_wrap;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && count_inc && !tb_clear && count == `ITB_COUNT_MAX)
      |=> (count == `ITB_COUNT_RESET) && o_overflow_request_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap or no overflow flag"); // [R9]

  property p_ovf_cause;
    @(posedge i_clk) disable iff (!rst_n)
      $rose(o_overflow_request_flag) |-> (count == `ITB_COUNT_RESET)
      && ($past(count) == `ITB_COUNT_MAX);
  endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without wrap"); // [R4]

  property p_clear;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && tb_clear) |=> (count == `ITB_COUNT_RESET) && (subclock_prescaler == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear left count or prescaler"); // [R10]

  property p_tb_rate;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && src == itb_pkg::ITB_SRC_SUB && !tb_clear && !sub_edge) |=> $stable(count);
  endproperty
  a_tb_rate: assert property (p_tb_rate) else $error("time base counted off subclock"); // [R3]

  property p_mode_read;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && i_rd && sel_mode) |=> (o_rdata == ($past(mode) | 8'h10));
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("bad mode readback"); // [R7]

  property p_count_read;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && i_rd && sel_count) |=> (o_rdata == $past(count));
  endproperty
  a_count_read: assert property (p_count_read) else $error("bad count readback"); // [R8]

  property p_count_ro;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && i_wr && sel_count && !count_inc && !tb_clear) |=> $stable(count);
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("count took a write"); // [R13]

  property p_pin_gate;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && !i_port_mode_reg_one_out_en) |=> !o_divided_clock_out_pin
      && !o_divided_clock_out_pin_en;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin driven while disabled"); // [R12]

  property p_pin_sel;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && i_port_mode_reg_one_out_en) |=> (o_divided_clock_out_pin == $past(sel_clk));
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("pin not the selected clock"); // [R5] [R11]

  // freeze check covers count, mode and both prescalers, so a stalled enable cannot shift the tap phase
  property p_freeze;
    @(posedge i_clk) disable iff (!rst_n)
      !i_ce |=> $stable(count) && $stable(mode) && $stable(system_prescaler) && $stable(subclock_prescaler);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low"); // [R1]

  property p_pss_run;
    @(posedge i_clk) disable iff (!rst_n)
      i_ce |=> (system_prescaler == $past(system_prescaler) + 1'b1);
  endproperty
  a_pss_run: assert property (p_pss_run) else $error("system prescaler skipped"); // [R2]

  property p_flag_pulse;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && o_overflow_request_flag) |=> !o_overflow_request_flag;
  endproperty
  a_flag_pulse: assert property (p_flag_pulse) else $error("overflow flag held"); // [R4]

  property p_flag_src;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && !wraps) |=> !o_overflow_request_flag;
  endproperty
  a_flag_src: assert property (p_flag_src) else $error("overflow flag without wrap"); // [R9]

  property p_mode_write;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && i_wr && sel_mode) |=> (mode == $past(i_wdata));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // [R7]

  // read data must fall back to zero so a stale value is never taken for a fresh read
  property p_rdata_idle;
    @(posedge i_clk) disable iff (!rst_n)
      (i_ce && !i_rd) |=> (o_rdata == `ITB_READ_NONE);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read"); // [R8]

  property p_pin_en;
    @(posedge i_clk) disable iff (!rst_n)
      i_ce |=> (o_divided_clock_out_pin_en == $past(i_port_mode_reg_one_out_en));
  endproperty
  a_pin_en: assert property (p_pin_en) else $error("pin enable lagging"); // [R12]

endmodule : itb_timer

// [verilog/itb_regs.svh]
// register map, field positions, reset values and timing figures of the interval timer
//
// Operation
// R1: One 8-bit up-counter works either as an interval timer or as a real-time clock time base.
// R2: In interval mode the counter is fed by one of eight system prescaler taps, /8 up to /8192.
// R3: In time-base mode, fed from 32.768 kHz, it overflows every 1 s, 0.5 s, 0.25 s or 31.25 ms.
// R4: Every counter overflow, in either mode, raises the overflow request.
// R5: The output pin carries the subclock or system clock divided by 32, 16, 8 or 4.
// R6: Time base needs the 32.768 kHz subclock; without it only interval and system output work.
// R7: The mode register is read/write at its fixed address and holds 0x10 after reset.
// R8: The count register is read-only at the next address and reads 0x00 after reset.
// R9: With source kind 0, the tap after 0xFF wraps the count to 0x00 and flags overflow.
// R10: With source kind 1, two bits pick the period; the clear bit zeroes count and prescaler.
// R11: Top three mode bits pick the output clock: top bit source, low two ratio, 000 default.
// R12: The divided clock reaches the pin only while the port mode output enable is 1.
// R13: Writes to the count register are ignored and reads never disturb counting.
`ifndef ITB_REGS_SVH
`define ITB_REGS_SVH

// ****************************************
// register map
// ****************************************
`define ITB_ADDR_W            16
`define ITB_MODE_OFFSET       16'hFFB0
`define ITB_COUNT_OFFSET      16'hFFB1
`define ITB_MODE_RESET        8'h10
`define ITB_COUNT_RESET       8'h00
`define ITB_COUNT_MAX         8'hFF
`define ITB_READ_NONE         8'h00

// ****************************************
// mode register fields
// ****************************************
`define ITB_OUT_SRC_BIT       7
`define ITB_OUT_RATIO_MSB     6
`define ITB_OUT_RATIO_LSB     5
`define ITB_RSVD_BIT          4
`define ITB_SRC_KIND_BIT      3
`define ITB_CLEAR_BIT         2
`define ITB_SEL_MSB           2
`define ITB_SEL_LSB           0
`define ITB_PERIOD_MSB        1
`define ITB_PERIOD_LSB        0

// ****************************************
// timing
// ****************************************
`define ITB_CLK_PERIOD_NS     10
`define ITB_SUBCLK_HZ         32768
`define ITB_PERIOD0_US        1000000
`define ITB_PERIOD1_US        500000
`define ITB_PERIOD2_US        250000
`define ITB_PERIOD3_US        31250
`define ITB_US_PER_S          1000000
`define ITB_COUNT_STEPS       256
// prescaler bit that toggles at source / 32; /16, /8, /4 sit one bit lower each
`define ITB_OUT_DIV32_BIT     4

`endif

// [verilog/itb_pkg.sv]
// shared types of the interval timer
package itb_pkg;
  typedef logic [7:0] itb_byte_type;

  // counter input source, one-hot
  typedef enum logic [1:0] {
    ITB_SRC_SYSTEM = 2'b01,
    ITB_SRC_SUB    = 2'b10
  } itb_src_type;
endpackage : itb_pkg

// [verilog/itb_sync.sv]
// two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ns
module itb_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else if (i_ce) begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : itb_sync

// [test/interval_timer_time_base_bench.sv]
// self-checking bench of the interval timer and time base
`timescale 1ns/1ns
`include "itb_regs.svh"
module interval_timer_time_base_bench;
  logic                   i_clk = 1'b0;
  logic                   i_rst_b = 1'b0;
  logic                   i_ce = 1'b1;
  logic                   i_subclock = 1'b0;
  logic                   i_port_mode_reg_one_out_en = 1'b0;
  logic [`ITB_ADDR_W-1:0] i_addr = '0;
  logic [7:0]             i_wdata = 8'h00;
  logic                   i_wr = 1'b0;
  logic                   i_rd = 1'b0;
  itb_pkg::itb_byte_type  o_rdata;
  logic                   o_overflow_request_flag;
  logic                   o_divided_clock_out_pin;
  logic                   o_divided_clock_out_pin_en;
  logic [1:0]             sub_div = 2'h0;
  int                     num_errors = 0;
  int                     checks_done = 0;
  itb_pkg::itb_byte_type  rd_a;
  itb_pkg::itb_byte_type  rd_b;
  logic [7:0]             val;
  int                     n;
  int                     k;

  itb_timer u_itb_timer (
    .i_clk                      (i_clk),
    .i_rst_b                    (i_rst_b),
    .i_ce                       (i_ce),
    .i_subclock                 (i_subclock),
    .i_port_mode_reg_one_out_en (i_port_mode_reg_one_out_en),
    .i_addr                     (i_addr),
    .i_wdata                    (i_wdata),
    .i_wr                       (i_wr),
    .i_rd                       (i_rd),
    .o_rdata                    (o_rdata),
    .o_overflow_request_flag    (o_overflow_request_flag),
    .o_divided_clock_out_pin    (o_divided_clock_out_pin),
    .o_divided_clock_out_pin_en (o_divided_clock_out_pin_en)
  );

  always #5 i_clk = ~i_clk;

  // fast stand-in subclock, one rise every 8 clocks, so periods stay short
  always @(posedge i_clk) begin
    sub_div <= sub_div + 2'h1;
    if (sub_div == 2'h3) begin
      i_subclock <= ~i_subclock;
    end
  end

  // ****************************************
  // expectations
  // ****************************************
  function automatic longint ovf_cycles(input logic [7:0] m);
    int     taps [8] = '{13, 12, 11, 9, 8, 7, 5, 3};
    longint us [4] = '{`ITB_PERIOD0_US, `ITB_PERIOD1_US, `ITB_PERIOD2_US, `ITB_PERIOD3_US};
    if (m[`ITB_SRC_KIND_BIT]) begin
      return longint'(`ITB_SUBCLK_HZ) * us[m[1:0]] / `ITB_US_PER_S * 8;
    end
    return longint'(`ITB_COUNT_STEPS) << taps[m[2:0]];
  endfunction : ovf_cycles

  function automatic int half_cycles(input logic [7:0] m);
    return (16 >> m[6:5]) * (m[`ITB_OUT_SRC_BIT] ? 8 : 1);
  endfunction : half_cycles

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("errors %0d, comparisons %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic do_reset();
    i_rst_b <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask : do_reset

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a, output itb_pkg::itb_byte_type d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask : bus_rd

  // cycles between the 2nd and 3rd event; the first span may be short
  task automatic span(input bit use_pin, input int limit, output int cnt);
    int   hits;
    logic prev;
    hits = 0;
    cnt = 0;
    @(negedge i_clk);
    prev = o_divided_clock_out_pin;
    for (int c = 0; c < limit && hits < 3; c++) begin
      @(negedge i_clk);
      if (hits == 2) cnt++;
      if (use_pin ? (o_divided_clock_out_pin !== prev) : (o_overflow_request_flag === 1'b1)) begin
        hits++;
      end
      prev = o_divided_clock_out_pin;
    end
  endtask : span

  initial begin
    repeat (80000) @(posedge i_clk);
    num_errors++;
    print_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h4ed3c102));
    do_reset();
    bus_rd(`ITB_MODE_OFFSET, rd_a);
    check(rd_a, `ITB_MODE_RESET, "mode reset");
    bus_rd(`ITB_COUNT_OFFSET, rd_a);
    check(rd_a, `ITB_COUNT_RESET, "count reset");
    for (k = 0; k < 6; k++) begin
      val = 8'($urandom);
      bus_wr(`ITB_MODE_OFFSET, val);
      bus_wr(16'hFFB2 + 16'($urandom % 16'h0040), ~val);
      bus_rd(`ITB_MODE_OFFSET, rd_a);
      check(rd_a, val | 8'h10, "mode readback");
    end
    bus_rd(16'hFFB5, rd_a);
    check(rd_a, `ITB_READ_NONE, "unmapped read");
    bus_wr(`ITB_MODE_OFFSET, 8'h0C);
    repeat (20) @(posedge i_clk);
    bus_wr(`ITB_COUNT_OFFSET, 8'h01 | 8'($urandom));
    bus_rd(`ITB_COUNT_OFFSET, rd_a);
    check(rd_a, 8'h00, "count held by clear");
    bus_wr(`ITB_MODE_OFFSET, 8'h07);
    for (k = 0; k < 4; k++) begin
      repeat ($urandom % 40) @(posedge i_clk);
      bus_rd(`ITB_COUNT_OFFSET, rd_a);
      bus_wr(`ITB_COUNT_OFFSET, 8'($urandom));
      repeat (4) @(posedge i_clk);
      bus_rd(`ITB_COUNT_OFFSET, rd_b);
      check(rd_b, 8'(rd_a + 8'h01), "count step per /8 tap");
    end
    // eight enabled edges around a long freeze still give exactly one /8 step
    bus_rd(`ITB_COUNT_OFFSET, rd_a);
    repeat (3) @(posedge i_clk);
    i_ce <= 1'b0;
    repeat (40) @(posedge i_clk);
    i_ce <= 1'b1;
    repeat (3) @(posedge i_clk);
    bus_rd(`ITB_COUNT_OFFSET, rd_b);
    check(rd_b, 8'(rd_a + 8'h01), "count frozen while disabled");
    for (k = 0; k < 2; k++) begin
      val = (k == 0) ? 8'h07 : 8'h06;
      bus_wr(`ITB_MODE_OFFSET, val);
      span(1'b0, 3 * int'(ovf_cycles(val)) + 50, n);
      check(n, ovf_cycles(val), "interval overflow period");
    end
    bus_wr(`ITB_MODE_OFFSET, 8'h0B);
    span(1'b0, 3 * int'(ovf_cycles(8'h0B)) + 50, n);
    check(n, ovf_cycles(8'h0B), "time base overflow period");
    @(posedge i_clk);
    i_port_mode_reg_one_out_en <= 1'b1;
    for (k = 0; k < 8; k++) begin
      val = {3'(k), 5'h07};
      bus_wr(`ITB_MODE_OFFSET, val);
      span(1'b1, 4 * half_cycles(val) + 20, n);
      check(n, half_cycles(val), "divided clock half period");
    end
    check(o_divided_clock_out_pin_en, 1'b1, "pin enable on");
    @(posedge i_clk);
    i_port_mode_reg_one_out_en <= 1'b0;
    repeat (2) @(posedge i_clk);
    n = 0;
    for (k = 0; k < 40; k++) begin
      @(negedge i_clk);
      if (o_divided_clock_out_pin !== 1'b0) n++;
    end
    check(n, 0, "pin quiet while disabled");
    check(o_divided_clock_out_pin_en, 1'b0, "pin enable off");
    @(posedge i_clk);
    do_reset();
    bus_rd(`ITB_MODE_OFFSET, rd_a);
    check(rd_a, `ITB_MODE_RESET, "mode after second reset");
    print_verdict();
  end
endmodule : interval_timer_time_base_bench
